//--- design/bic_defs.svh
// Register offsets, field positions and reset values of the bus cycle block
`ifndef BIC_DEFS_SVH
`define BIC_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BIC_OFS_BUS_CTRL   4'h0
`define BIC_OFS_ACC_STATE  4'h4
`define BIC_OFS_DRAM_B     4'h8
`define BIC_OFS_STATUS     4'hC
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIC_BC_BURST_EN    0
`define BIC_BC_LEN_SEL     1
`define BIC_BC_TIME_SEL    2
`define BIC_BC_RW_IDLE     3
`define BIC_BC_RR_IDLE     4
`define BIC_AS_AREA0       0
`define BIC_AS_WAIT_LO     1
`define BIC_AS_WAIT_HI     2
`define BIC_DB_COL_WR      0
`define BIC_DB_RAS_DOWN    1
// ----------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------
`define BIC_BC_RESET       8'h18
`define BIC_AS_RESET       8'h07
`define BIC_DB_RESET       16'h0000
`define BIC_AREA0          3'h0
`define BIC_WORD_STEP      24'h000002
`endif

//--- design/bic_pkg.sv
// Types shared by the bus cycle block
package bic_pkg;
    // Bus cycle sequencer states
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_TI  = 4'h1, S_TP  = 4'h2, S_T1  = 4'h3,
        S_T2   = 4'h4, S_TW  = 4'h5, S_T3  = 4'h6, S_TB1 = 4'h7,
        S_TB2  = 4'h8, S_TB3 = 4'h9
    } bic_state_t;
    // Request from the internal bus master
    typedef struct packed {
        logic        we;
        logic [23:0] addr;
        logic [15:0] wdata;
    } bic_req_t;
    // External pin group, strobes active low
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dout;
        logic        data_oe;
        logic [7:0]  area_select_n;
        logic        address_strobe_n;
        logic        read_strobe_n;
        logic        upper_write_strobe_n;
        logic        lower_write_strobe_n;
        logic        upper_column_strobe_n;
        logic        lower_column_strobe_n;
    } bic_pins_t;
endpackage

//--- design/bic_ctrl.sv
// Burst ROM and idle cycle sequencer for the external bus
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`include "bic_defs.svh"
`timescale 1ns/100ps
module bic_ctrl (
    input  wire logic                 clk,          // 40 MHz clock
    input  wire logic                 reset,        // Async reset, high
    input  wire logic [3:0]           avs_address,  // Register byte addr
    input  wire logic                 avs_read,     // Register read
    input  wire logic                 avs_write,    // Register write
    input  wire logic [3:0]           avs_byteenable, // Write lanes
    input  wire logic [31:0]          avs_writedata, // Write data
    output logic      [31:0]          avs_readdata, // Read data
    output logic                      avs_waitrequest, // Stall
    input  wire logic                 cpu_req,      // Bus cycle request
    input  wire bic_pkg::bic_req_t    cpu_cmd,      // Request fields
    output logic                      cpu_ack,      // Cycle done pulse
    output logic      [15:0]          cpu_rdata,    // Read word
    input  wire logic                 wait_n,       // External wait pin
    input  wire logic [15:0]          ext_din,      // Data bus input
    output bic_pkg::bic_pins_t        pins          // External pins
);
    import bic_pkg::*;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [7:0]  bus_control_reg, bus_control_next;   // Burst and idle
    logic [7:0]  access_state_control_reg, access_state_control_next;
    logic [15:0] dram_control_reg_b, dram_control_b_next; // DRAM setup
    logic        wait_req_reg, wait_req_next;         // Bus stall
    logic [31:0] rdata_reg, rdata_next;               // Bus read data
    bic_state_t  state_reg, state_next;               // Sequencer
    bic_req_t    req_reg, req_next;                   // Latched request
    bic_pins_t   pins_reg, pins_next;                 // Pin registers
    logic [1:0]  wcnt_reg, wcnt_next;                 // Program waits
    logic        ack_reg, ack_next;                   // Done pulse
    logic [15:0] cdata_reg, cdata_next;               // Read word
    logic        prev_ok_reg, prev_ok_next;           // Last cycle known
    logic        prev_rd_reg, prev_rd_next;           // Last was read
    logic        prev_dram_reg, prev_dram_next;       // Last was DRAM
    logic [2:0]  prev_area_reg, prev_area_next;       // Last area
    logic        burst_reg, burst_next;               // Burst may go on
    logic [23:0] last_addr_reg, last_addr_next;       // Last burst word

    // Decoded controls
    logic        burst_en, len8, time3, rw_idle, rr_idle, area0_3st;
    logic [1:0]  prog_waits;
    logic        col_wr, ras_down;
    logic [7:0]  dram_areas;
    logic        start, tgt_dram, cont_burst, same_block, done;
    logic [2:0]  area, cur_area;
    bic_req_t    cur;

    assign burst_en   = bus_control_reg[`BIC_BC_BURST_EN];
    assign len8       = bus_control_reg[`BIC_BC_LEN_SEL];
    assign time3      = bus_control_reg[`BIC_BC_TIME_SEL];
    assign rw_idle    = bus_control_reg[`BIC_BC_RW_IDLE];
    assign rr_idle    = bus_control_reg[`BIC_BC_RR_IDLE];
    assign area0_3st  = access_state_control_reg[`BIC_AS_AREA0];
    assign prog_waits = access_state_control_reg[`BIC_AS_WAIT_HI:
                                                 `BIC_AS_WAIT_LO];
    assign col_wr     = dram_control_reg_b[`BIC_DB_COL_WR];
    assign ras_down   = dram_control_reg_b[`BIC_DB_RAS_DOWN];
    assign dram_areas = dram_control_reg_b[15:8];
    assign area       = cpu_cmd.addr[23:21];
    assign tgt_dram   = dram_areas[area];
    assign start      = (state_reg == S_IDLE) && cpu_req && !ack_reg;
    assign cur        = start ? cpu_cmd : req_reg;
    assign cur_area   = cur.addr[23:21];

    // Block boundary for four or eight word bursts
    assign same_block = len8 ? (cpu_cmd.addr[23:4] == last_addr_reg[23:4])
                             : (cpu_cmd.addr[23:3] == last_addr_reg[23:3]);
    assign cont_burst = burst_reg && burst_en && !cpu_cmd.we
                        && (area == `BIC_AREA0) && same_block
                        && (cpu_cmd.addr == last_addr_reg + `BIC_WORD_STEP);

    // ------------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------------
    // One stall cycle, then a single cycle answer per access
    always_comb begin
        bus_control_next          = bus_control_reg;
        access_state_control_next = access_state_control_reg;
        dram_control_b_next       = dram_control_reg_b;
        rdata_next                = rdata_reg;
        wait_req_next             = 1'b1;
        if ((avs_read || avs_write) && wait_req_reg) begin
            wait_req_next = 1'b0;
            rdata_next    = 32'h0000_0000;
            // Stores take effect at the answering edge
            if (avs_write && avs_byteenable[0]) begin
                case (avs_address)
                    `BIC_OFS_BUS_CTRL:
                        bus_control_next = avs_writedata[7:0];
                    `BIC_OFS_ACC_STATE:
                        access_state_control_next = avs_writedata[7:0];
                    `BIC_OFS_DRAM_B:
                        dram_control_b_next[7:0] = avs_writedata[7:0];
                    default: ;
                endcase
            end
            if (avs_write && avs_byteenable[1] &&
                avs_address == `BIC_OFS_DRAM_B) begin
                dram_control_b_next[15:8] = avs_writedata[15:8];
            end
            // Unmapped offsets read as zero
            case (avs_address)
                `BIC_OFS_BUS_CTRL:  rdata_next[7:0]  = bus_control_reg;
                `BIC_OFS_ACC_STATE:
                    rdata_next[7:0] = access_state_control_reg;
                `BIC_OFS_DRAM_B:    rdata_next[15:0] = dram_control_reg_b;
                `BIC_OFS_STATUS:    rdata_next[6:0]  = {prev_dram_reg,
                                        burst_reg, prev_rd_reg, state_reg};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------------
    // Final state of every external cycle
    assign done = (state_reg == S_T2 && !area0_3st && req_reg.addr[23:21]
                   == `BIC_AREA0) || (state_reg == S_T3)
                  || (state_reg == S_TB2 && !time3) || (state_reg == S_TB3);

    // Next state, idle decisions and burst tracking
    always_comb begin
        state_next     = state_reg;
        req_next       = req_reg;
        wcnt_next      = wcnt_reg;
        ack_next       = 1'b0;
        cdata_next     = cdata_reg;
        prev_ok_next   = prev_ok_reg;
        prev_rd_next   = prev_rd_reg;
        prev_dram_next = prev_dram_reg;
        prev_area_next = prev_area_reg;
        burst_next     = burst_reg;
        last_addr_next = last_addr_reg;
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    req_next   = cpu_cmd;
                    burst_next = 1'b0;
                    if (cont_burst && prev_ok_reg) begin
                        state_next = S_TB1;
                    end else if (tgt_dram) begin
                        state_next = S_TP;
                    end else if (prev_ok_reg && prev_dram_reg && col_wr) begin
                        state_next = S_TI;
                    end else if (prev_ok_reg && prev_rd_reg && !cpu_cmd.we
                                 && rr_idle && area != prev_area_reg) begin
                        state_next = S_TI;
                    end else if (prev_ok_reg && prev_rd_reg && cpu_cmd.we
                                 && rw_idle) begin
                        state_next = S_TI;
                    end else begin
                        state_next = S_T1;
                    end
                end else if (!cpu_req && !ack_reg) begin
                    prev_ok_next = 1'b0;  // Bus went quiet
                    burst_next   = 1'b0;
                end
            end
            S_TI:    state_next = S_T1;
            S_TP:    state_next = S_T1;
            S_T1:    state_next = S_T2;
            S_T2: begin
                // Area 0 with the state bit clear ends here
                if (req_reg.addr[23:21] == `BIC_AREA0 && !area0_3st) begin
                    state_next = S_IDLE;
                end else if (prog_waits != 2'h0 || !wait_n) begin
                    state_next = S_TW;
                    wcnt_next  = prog_waits;
                end else begin
                    state_next = S_T3;
                end
            end
            S_TW: begin
                if (wcnt_reg != 2'h0) begin
                    wcnt_next = wcnt_reg - 2'h1;
                end
                if (wcnt_reg <= 2'h1 && wait_n) begin
                    state_next = S_T3;
                end
            end
            S_T3:    state_next = S_IDLE;
            S_TB1:   state_next = S_TB2;
            S_TB2:   state_next = time3 ? S_TB3 : S_IDLE;
            S_TB3:   state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
        if (done) begin
            ack_next       = 1'b1;
            cdata_next     = ext_din;
            prev_ok_next   = 1'b1;
            prev_rd_next   = !req_reg.we;
            prev_area_next = req_reg.addr[23:21];
            prev_dram_next = dram_areas[req_reg.addr[23:21]];
            last_addr_next = req_reg.addr;
            burst_next     = burst_en && !req_reg.we &&
                             req_reg.addr[23:21] == `BIC_AREA0;
        end
    end

    // Pin values for the coming state
    always_comb begin
        pins_next                       = pins_reg;
        pins_next.data_oe               = 1'b0;
        pins_next.address_strobe_n      = 1'b1;
        pins_next.read_strobe_n         = 1'b1;
        pins_next.upper_write_strobe_n  = 1'b1;
        pins_next.lower_write_strobe_n  = 1'b1;
        pins_next.upper_column_strobe_n = 1'b1;
        pins_next.lower_column_strobe_n = 1'b1;
        pins_next.area_select_n         = 8'hFF;
        case (state_next)
            S_IDLE, S_TI, S_TP: begin
                if (state_next != S_IDLE) begin
                    pins_next.addr = cur.addr;
                end
                // RAS down keeps the DRAM select low between cycles;
                // a cycle ending now counts as the last access
                if (ras_down && state_next != S_TP && (done ?
                    dram_areas[req_reg.addr[23:21]] : prev_dram_reg)) begin
                    pins_next.area_select_n = pins_reg.area_select_n;
                end
            end
            default: begin
                pins_next.addr = cur.addr;
                pins_next.dout = cur.wdata;
                pins_next.area_select_n[cur_area] = 1'b0;
                pins_next.read_strobe_n = cur.we;
                pins_next.data_oe       = cur.we;
                if (!dram_areas[cur_area]) begin
                    pins_next.address_strobe_n = 1'b0;
                    if (cur.we && state_next != S_T1) begin
                        pins_next.upper_write_strobe_n = 1'b0;
                        pins_next.lower_write_strobe_n = 1'b0;
                    end
                end else if (state_next != S_T1) begin
                    // Column strobes on write or port B pins
                    if (col_wr) begin
                        pins_next.upper_write_strobe_n = 1'b0;
                        pins_next.lower_write_strobe_n = 1'b0;
                    end else begin
                        pins_next.upper_column_strobe_n = 1'b0;
                        pins_next.lower_column_strobe_n = 1'b0;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_control_reg          <= `BIC_BC_RESET;
            access_state_control_reg <= `BIC_AS_RESET;
            dram_control_reg_b       <= `BIC_DB_RESET;
            wait_req_reg             <= 1'b1;
            rdata_reg                <= 32'h0000_0000;
            state_reg                <= S_IDLE;
            req_reg                  <= '0;
            pins_reg                 <= '{addr: 24'h000000, dout: 16'h0000,
                                          data_oe: 1'b0,
                                          area_select_n: 8'hFF,
                                          default: 1'b1};
            wcnt_reg                 <= 2'h0;
            ack_reg                  <= 1'b0;
            cdata_reg                <= 16'h0000;
            prev_ok_reg              <= 1'b0;
            prev_rd_reg              <= 1'b0;
            prev_dram_reg            <= 1'b0;
            prev_area_reg            <= 3'h0;
            burst_reg                <= 1'b0;
            last_addr_reg            <= 24'h000000;
        end else begin
            bus_control_reg          <= bus_control_next;
            access_state_control_reg <= access_state_control_next;
            dram_control_reg_b       <= dram_control_b_next;
            wait_req_reg             <= wait_req_next;
            rdata_reg                <= rdata_next;
            state_reg                <= state_next;
            req_reg                  <= req_next;
            pins_reg                 <= pins_next;
            wcnt_reg                 <= wcnt_next;
            ack_reg                  <= ack_next;
            cdata_reg                <= cdata_next;
            prev_ok_reg              <= prev_ok_next;
            prev_rd_reg              <= prev_rd_next;
            prev_dram_reg            <= prev_dram_next;
            prev_area_reg            <= prev_area_next;
            burst_reg                <= burst_next;
            last_addr_reg            <= last_addr_next;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_req_reg;
    assign cpu_ack         = ack_reg;
    assign cpu_rdata       = cdata_reg;
    assign pins            = pins_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_BURST_GATE: assert property (@(posedge clk) disable iff (reset)
        (state_reg == S_IDLE && state_next == S_TB1) |-> burst_en)
        else $error("burst started with burst space disabled");
    AST_BURST_NOWAIT: assert property (@(posedge clk) disable iff (reset)
        state_reg == S_TB1 |=> state_reg == S_TB2 ##1
        (state_reg == S_TB3 || state_reg == S_IDLE))
        else $error("burst cycle was stretched");
    AST_BURST_TIME: assert property (@(posedge clk) disable iff (reset)
        (state_reg == S_TB2 && !time3) |=> state_reg == S_IDLE && ack_reg)
        else $error("two state burst cycle ran long");
    AST_AREA0_SHORT: assert property (@(posedge clk) disable iff (reset)
        (state_reg == S_T1 && req_reg.addr[23:21] == `BIC_AREA0
         && !area0_3st) |=> ##1 ack_reg)
        else $error("two state initial access not two states");
    AST_WAIT_PIN: assert property (@(posedge clk) disable iff (reset)
        (state_reg == S_TW && wcnt_reg <= 2'h1 && !wait_n)
        |=> state_reg == S_TW)
        else $error("wait pin ignored in initial access");
    AST_IDLE_PINS: assert property (@(posedge clk) disable iff (reset)
        state_reg == S_TI |-> !pins.data_oe && pins.read_strobe_n &&
        pins.address_strobe_n && pins.addr == req_reg.addr)
        else $error("idle state pins wrong");
    AST_DRAM_TP: assert property (@(posedge clk) disable iff (reset)
        state_reg == S_TP |-> $past(state_reg) == S_IDLE)
        else $error("idle state placed before precharge");
    AST_FORCED_IDLE: assert property (@(posedge clk) disable iff (reset)
        (start && prev_ok_reg && prev_dram_reg && col_wr && !tgt_dram &&
         !cont_burst) |=> state_reg == S_TI)
        else $error("no idle after DRAM with strobe column pins");
    AST_RR_IDLE: assert property (@(posedge clk) disable iff (reset)
        (start && prev_ok_reg && prev_rd_reg && !cpu_cmd.we && rr_idle &&
         !tgt_dram && !cont_burst && area != prev_area_reg)
        |=> state_reg == S_TI ##1 state_reg == S_T1)
        else $error("no idle between reads of two areas");
    AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (reset)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
        ##1 avs_waitrequest)
        else $error("register access not answered in one cycle");
endmodule

//--- verification/bic_mem_model.sv
// Far-side model: 16-bit burst ROM and SRAM on the external pins
`timescale 1ns/100ps
module bic_mem_model (
    input  wire logic              clk,     // System clock
    input  wire bic_pkg::bic_pins_t pins,   // Pins from the controller
    output logic [15:0]            ext_din, // Data bus to the controller
    output logic                   wait_n   // Wait pin, slow words only
);
    import bic_pkg::*;
    logic [15:0] last_q;     // Last word seen on the bus
    logic [1:0]  strobe_age; // Cycles since the address strobe fell
    // Age of the current strobe, held at three
    always_ff @(posedge clk) begin
        if (pins.address_strobe_n) begin
            strobe_age <= 2'h0;
        end else if (strobe_age != 2'h3) begin
            strobe_age <= strobe_age + 2'h1;
        end
    end
    // Released bus flips every cycle so a stale word never matches
    always_ff @(posedge clk) begin
        last_q <= pins.read_strobe_n ? ~last_q : ext_din;
    end
    // Word of a 16-bit organised memory, derived from its address
    assign ext_din = pins.read_strobe_n ? last_q
                                        : pins.addr[15:0] ^ 16'h5A3C;
    // Words with address bit 12 set hold the wait pin for three states
    assign wait_n  = !(pins.addr[12] && !pins.address_strobe_n &&
                       strobe_age != 2'h3);
endmodule

//--- verification/burst_rom_idle_cycle_ctrl_bench.sv
// Self-checking bench of the burst ROM and idle cycle controller
`timescale 1ns/100ps
`include "bic_defs.svh"
module burst_rom_idle_cycle_ctrl_bench;
    import bic_pkg::*;
    logic        clk, reset, avs_read, avs_write, cpu_req, cpu_ack;
    logic        avs_waitrequest, wait_n;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] cpu_rdata, ext_din;
    bic_req_t    cpu_cmd;
    bic_pins_t   pins, idle_pins;
    logic [14:0] idle_exp = 15'h3FFF; // Pin word expected in an idle state
    int          miscompares = 0;
    int          checks_done = 0;
    bic_ctrl bic_ctrl_inst (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'h3),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req),
        .cpu_cmd(cpu_cmd), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
        .wait_n(wait_n), .ext_din(ext_din), .pins(pins));
    bic_mem_model bic_mem_model_inst (.clk(clk), .pins(pins),
        .ext_din(ext_din), .wait_n(wait_n));
    // ------------------------------------------------------------------
    // Clock, verdict and compare
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ------------------------------------------------------------------
    // Register bus access, held until waitrequest samples low
    // ------------------------------------------------------------------
    task automatic reg_acc(logic wr, logic [3:0] a, logic [31:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin miscompares++; final_report(); end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // Bus cycle kept back to back; lat below zero skips the timing check
    task automatic cyc(logic we, logic [23:0] a, int lat, logic idle);
        int n;
        cpu_cmd <= '{we, a, a[15:0]};
        cpu_req <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (n == 1) idle_pins = pins;
            if (cpu_ack === 1'b1) break;
        end
        if (n == 60) begin miscompares++; final_report(); end
        if (lat >= 0) chk("latency", lat, n);
        if (!we) chk("read word", a[15:0] ^ 16'h5A3C, cpu_rdata);
        if (idle) chk("idle address", a, idle_pins.addr);
        if (idle) chk("idle pins", idle_exp, idle_pins[14:0]);
    endtask
    task automatic rest;
        cpu_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset;
        chk("reset pins", 32'h3FFF, pins[14:0]);
        reg_acc(0, `BIC_OFS_BUS_CTRL, 0);
        chk("bus control", 32'h18, q);
        reg_acc(0, `BIC_OFS_ACC_STATE, 0);
        chk("access state", 32'h07, q);
        reg_acc(0, 4'h2, 0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
    endtask
    task automatic test_burst(logic len, logic tim);
        int w;
        w = len ? 8 : 4;
        reg_acc(1, `BIC_OFS_BUS_CTRL, {tim, len, 1'b1});
        reg_acc(1, `BIC_OFS_ACC_STATE, 32'h01);
        cyc(0, 24'h0, 4, 0);
        for (int i = 1; i < w; i++) cyc(0, 2 * i, tim ? 4 : 3, 0);
        cyc(0, 2 * w, 4, 0);
        rest();
        $display("test burst %0d words %0d states done", w, tim + 2);
    endtask
    task automatic test_waits;
        reg_acc(1, `BIC_OFS_BUS_CTRL, 32'h01);
        reg_acc(1, `BIC_OFS_ACC_STATE, 32'h06);
        cyc(0, 24'h10, 3, 0);
        rest();
        reg_acc(1, `BIC_OFS_ACC_STATE, 32'h03);
        cyc(0, 24'h20, 5, 0);
        cyc(0, 24'h22, 3, 0);
        cyc(0, 24'h001000, 6, 0);
        rest();
        $display("test waits done");
    endtask
    task automatic test_idle(logic on);
        reg_acc(1, `BIC_OFS_ACC_STATE, 32'h01);
        reg_acc(1, `BIC_OFS_BUS_CTRL, on ? 32'h18 : 32'h00);
        cyc(0, 24'h200000, -1, 0);
        cyc(0, 24'h200002, 4, 0);
        cyc(0, 24'h000000, on ? 5 : 4, on);
        cyc(1, 24'h200004, on ? 5 : 4, on);
        rest();
        $display("test idle enabled %0d done", on);
    endtask
    task automatic test_dram(logic col);
        reg_acc(1, `BIC_OFS_BUS_CTRL, 32'h10);
        reg_acc(1, `BIC_OFS_DRAM_B, {8'h04, 6'h0, col, col});
        idle_exp = col ? 15'h3EFF : 15'h3FFF;
        cyc(0, 24'h200000, -1, 0);
        cyc(0, 24'h400000, 5, 0);
        cyc(1, 24'h200000, col ? 5 : 4, col);
        idle_exp = 15'h3FFF;
        rest();
        $display("test dram column choice %0d done", col);
    endtask
    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        cpu_req = 1'b0;
        cpu_cmd = '0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        test_reset();
        for (int k = 0; k < 4; k++) test_burst(k[1], k[0]);
        test_waits();
        test_idle(1);
        test_idle(0);
        test_dram(1);
        test_dram(0);
        final_report();
    end
endmodule
